// *** hdl/motor_ramp_cfg.svh ***
// Purpose: offsets, fields, resets and timing for the start ramp block
// Assumes: 200 MHz clock, AXI4-Lite byte addresses
// Notes:   definitions only
`ifndef MOTOR_RAMP_CFG_SVH
`define MOTOR_RAMP_CFG_SVH
`define A_CTRL      8'h00
`define A_FLC       8'h04
`define A_SF        8'h08
`define A_CLS       8'h0c
`define A_INIT      8'h10
`define A_MAX       8'h14
`define A_RAMP      8'h18
`define A_SRT       8'h1c
`define A_JUMP      8'h20
`define A_STAT      8'h24
`define A_IRQ_STS   8'h28
`define A_IRQ_MSK   8'h2c
`define A_LIMIT     8'h30
`define F_LR        0
`define F_KSD       1
`define F_LSRC      3:2
`define F_RSRC      5:4
`define F_LRIN      6
`define F_SEP       7
`define RST_CTRL    8'h14
`define RST_FLC     13'h000a
`define RST_SF      8'h73
`define RST_CLS     6'h0a
`define RST_INIT    10'h064
`define RST_MAX     10'h258
`define RST_RAMP    9'h00f
`define RST_SRT     9'h014
`define SRC_KEYPAD  2'h0
`define SRC_TERM    2'h1
`define SRC_SERIAL  2'h2
`define SPEED_PCT   10'h0af
`define OL_TRIP     7'h64
`define FAULT_STALL 8'h01
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`define CLK_NS      5
`define TICK_NS     1000000
`define TICKS_PER_S 19'h003e8
`define EV_STALL    0
`define EV_SPEED    1
`define EV_TRIP     2
`endif

// *** hdl/motor_ramp_pkg.sv ***
// Purpose: shared types of the start ramp block
// Assumes: nothing
// Notes:   constants live in motor_ramp_cfg.svh
package motor_ramp_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_RAMP, ST_HOLD, ST_RUN} state_t;
    typedef logic [1:0] src_t;
endpackage : motor_ramp_pkg

// *** hdl/motor_ramp.sv ***
// Purpose: start/stop source select and current ramp of a soft starter
// Assumes: all inputs except arst_n synchronous to clk; command inputs are pulses
// Notes:   ramp and timers advance on a 1 ms control tick
//
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "motor_ramp_cfg.svh"
// Operation
// R1: selector input low picks local source
// R2: selector input high picks remote source
// R3: no selector input: control bit, reset local
// R4: sources keypad, terminal, serial; default terminal
// R5: keypad stop always stops unless disabled
// R6: full-load current 1..6400 scales limits
// R7: service factor 1.00..1.99, default 1.15
// R8: running class sets both start and run
// R9: overload state percent, 100 means tripped
// R10: class off disables overload everywhere
// R11: start begins at initial current
// R12: software keeps initial below maximum
// R13: maximum ends ramp and limits afterwards
// R14: hold maximum until speed, timer or trip
// R15: ramp initial to maximum over ramp time
// R16: jump entry plus enter moves display
// R17: up to speed: below 175% after ramp
// R18: timer expiry before speed raises fault 01
// R19: linear steps, maximum exactly at ramp end
module motor_ramp #(
    parameter int TICK_CYCLES = `TICK_NS / `CLK_NS
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // axi4-lite slave
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // start/stop sources
    input  wire logic        kp_start,
    input  wire logic        kp_stop,
    input  wire logic        kp_enter,
    input  wire logic        ts_start,
    input  wire logic        ts_stop,
    input  wire logic        net_start,
    input  wire logic        net_stop,
    input  wire logic        lr_pin,
    // motor feedback
    input  wire logic [9:0]  cur_pct,
    input  wire logic [6:0]  ol_heat_pct,
    // starter outputs
    output logic             motor_run_q,
    output logic             up_to_speed_q,
    output logic [22:0]      limit_ca_q,
    output logic [7:0]       fault_code_q,
    output logic [7:0]       service_factor_q,
    output logic [5:0]       ol_class_q,
    output logic             ol_enable_q,
    output logic [7:0]       display_param_q,
    output logic             irq_q
);
    motor_ramp_pkg::state_t state_q;
    logic [7:0]  ctrl_q;
    logic [12:0] flc_q;
    logic [7:0]  sf_q;
    logic [5:0]  cls_q;
    logic [9:0]  init_q, max_q, lim_q;
    logic [8:0]  ramp_q, srt_q;
    logic [7:0]  jump_q;
    logic [2:0]  sts_q, msk_q, ev_q;
    logic [6:0]  ol_state_q;
    logic [17:0] tick_cnt_q;
    logic        tick;
    logic [18:0] ramp_ms_q, srt_ms_q, ramp_n, srt_n;
    logic [19:0] err_q, err_sum;
    logic [9:0]  delta;
    logic        aw_q, ar_q, bv_q, rv_q, ol_trip;
    logic [31:0] rd_d, wr_m;
    logic [1:0]  rresp_q, bresp_q;
    logic [31:0] rdata_q;
    motor_ramp_pkg::src_t sel_src;
    logic        start_cmd, stop_cmd, wr_hit, wr_ok;

    assign awready = aw_q;
    assign wready  = aw_q;
    assign bvalid  = bv_q;
    assign bresp   = bresp_q;
    assign arready = ar_q;
    assign rvalid  = rv_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;

    // source selection
    always_comb begin
        if (ctrl_q[`F_LRIN]) begin
            sel_src = lr_pin ? ctrl_q[`F_RSRC] : ctrl_q[`F_LSRC]; // R1 R2
        end else begin
            sel_src = ctrl_q[`F_LR] ? ctrl_q[`F_RSRC] : ctrl_q[`F_LSRC]; // R3
        end
        case (sel_src) // R4
            `SRC_KEYPAD: begin
                start_cmd = kp_start;
                stop_cmd  = kp_stop;
            end
            `SRC_TERM: begin
                start_cmd = ts_start;
                stop_cmd  = ts_stop;
            end
            `SRC_SERIAL: begin
                start_cmd = net_start;
                stop_cmd  = net_stop;
            end
            default: begin
                start_cmd = 1'b0;
                stop_cmd  = 1'b1;
            end
        endcase
        if (kp_stop && !ctrl_q[`F_KSD]) begin
            stop_cmd = 1'b1; // R5
        end
    end

    // ramp arithmetic
    assign ramp_n  = 19'(ramp_q) * `TICKS_PER_S;
    assign srt_n   = 19'(srt_q) * `TICKS_PER_S;
    assign delta   = (max_q > init_q) ? max_q - init_q : 10'h000;
    assign err_sum = err_q + 20'(delta);
    assign ol_trip = ol_enable_q && (ol_state_q == `OL_TRIP); // R9
    assign tick    = (tick_cnt_q == 18'(TICK_CYCLES - 1));

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_q <= 18'h00000;
        end else begin
            tick_cnt_q <= tick ? 18'h00000 : tick_cnt_q + 18'h00001;
        end
    end

    // overload bookkeeping; the thermal model itself lives elsewhere
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ol_state_q  <= 7'h00;
            ol_enable_q <= 1'b1;
            ol_class_q  <= `RST_CLS;
            service_factor_q <= `RST_SF;
        end else begin
            ol_state_q  <= (ol_heat_pct > `OL_TRIP) ? `OL_TRIP : ol_heat_pct; // R9
            ol_enable_q <= (cls_q != 6'h00); // R10
            ol_class_q  <= cls_q; // R8
            service_factor_q <= sf_q; // R7
        end
    end

    // start sequencer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q   <= motor_ramp_pkg::ST_IDLE;
            lim_q     <= 10'h000;
            err_q     <= 20'h00000;
            ramp_ms_q <= 19'h00000;
            srt_ms_q  <= 19'h00000;
            ev_q      <= 3'h0;
            fault_code_q <= 8'h00;
        end else begin
            ev_q <= 3'h0;
            case (state_q)
                motor_ramp_pkg::ST_IDLE: begin
                    if (start_cmd && !stop_cmd && !ol_trip) begin
                        err_q     <= 20'h00000;
                        ramp_ms_q <= 19'h00000;
                        srt_ms_q  <= 19'h00000;
                        fault_code_q <= 8'h00;
                        if (ramp_n == 19'h00000) begin
                            state_q <= motor_ramp_pkg::ST_HOLD;
                            lim_q   <= max_q; // R15
                        end else begin
                            state_q <= motor_ramp_pkg::ST_RAMP;
                            lim_q   <= init_q; // R11
                        end
                    end
                end
                motor_ramp_pkg::ST_RAMP, motor_ramp_pkg::ST_HOLD: begin
                    if (tick) begin
                        srt_ms_q <= srt_ms_q + 19'h00001;
                    end
                    if (stop_cmd) begin
                        state_q <= motor_ramp_pkg::ST_IDLE;
                        lim_q   <= 10'h000;
                    end else if (ol_trip) begin
                        state_q <= motor_ramp_pkg::ST_IDLE; // R14
                        lim_q   <= 10'h000;
                        ev_q[`EV_TRIP] <= 1'b1;
                    end else if (tick && srt_ms_q + 19'h00001 >= srt_n) begin
                        state_q <= motor_ramp_pkg::ST_IDLE; // R18
                        lim_q   <= 10'h000;
                        fault_code_q <= `FAULT_STALL;
                        ev_q[`EV_STALL] <= 1'b1;
                    end else if (state_q == motor_ramp_pkg::ST_HOLD) begin
                        lim_q <= max_q; // R14
                        if (cur_pct < `SPEED_PCT) begin
                            state_q <= motor_ramp_pkg::ST_RUN; // R17
                            ev_q[`EV_SPEED] <= 1'b1;
                        end
                    end else if (tick) begin
                        ramp_ms_q <= ramp_ms_q + 19'h00001;
                        // at most one step per tick, which keeps pace while delta <= ramp_n (ramp_n >= 1000)
                        if (ramp_ms_q + 19'h00001 >= ramp_n) begin
                            state_q <= motor_ramp_pkg::ST_HOLD;
                            lim_q   <= max_q; // R19
                        end else if (err_sum >= 20'(ramp_n)) begin
                            err_q <= err_sum - 20'(ramp_n);
                            lim_q <= lim_q + 10'h001; // R15 R19
                        end else begin
                            err_q <= err_sum;
                        end
                    end
                end
                motor_ramp_pkg::ST_RUN: begin
                    lim_q <= max_q; // R13
                    if (stop_cmd || ol_trip) begin
                        state_q <= motor_ramp_pkg::ST_IDLE;
                        lim_q   <= 10'h000;
                        ev_q[`EV_TRIP] <= ol_trip;
                    end
                end
                default: begin
                    state_q <= motor_ramp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // starter outputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            motor_run_q     <= 1'b0;
            up_to_speed_q   <= 1'b0;
            limit_ca_q      <= 23'h000000;
            display_param_q <= 8'h00;
            irq_q           <= 1'b0;
        end else begin
            motor_run_q   <= (state_q != motor_ramp_pkg::ST_IDLE);
            up_to_speed_q <= (state_q == motor_ramp_pkg::ST_RUN);
            limit_ca_q    <= 23'(flc_q) * 23'(lim_q); // R6
            if (kp_enter) begin
                display_param_q <= jump_q; // R16
            end
            irq_q <= |(sts_q & msk_q);
        end
    end

    // axi4-lite write: both channels taken together
    assign wr_hit = aw_q && awvalid && wvalid;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wr_m[i*8 +: 8] = wstrb[i] ? wdata[i*8 +: 8] : 8'h00;
        end
        case (awaddr)
            `A_CTRL, `A_FLC, `A_SF, `A_CLS, `A_INIT, `A_MAX, `A_RAMP, `A_SRT,
            `A_JUMP, `A_STAT, `A_IRQ_STS, `A_IRQ_MSK, `A_LIMIT: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_q    <= 1'b0;
            bv_q    <= 1'b0;
            bresp_q <= `RESP_OKAY;
        end else begin
            aw_q <= awvalid && wvalid && !aw_q && !bv_q;
            if (wr_hit) begin
                bv_q    <= 1'b1;
                bresp_q <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bready) begin
                bv_q <= 1'b0;
            end
        end
    end

    // configuration registers; partial strobes clear unwritten lanes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= `RST_CTRL; // R3 R4
            flc_q  <= `RST_FLC;
            sf_q   <= `RST_SF;
            cls_q  <= `RST_CLS;
            init_q <= `RST_INIT;
            max_q  <= `RST_MAX;
            ramp_q <= `RST_RAMP;
            srt_q  <= `RST_SRT;
            jump_q <= 8'h00;
            msk_q  <= 3'h0;
        end else if (wr_hit) begin
            case (awaddr)
                `A_CTRL:    ctrl_q <= wr_m[7:0];
                `A_FLC:     flc_q  <= wr_m[12:0];
                `A_SF:      sf_q   <= wr_m[7:0];
                `A_CLS:     cls_q  <= wr_m[5:0];
                `A_INIT:    init_q <= wr_m[9:0];
                `A_MAX:     max_q  <= wr_m[9:0];
                `A_RAMP:    ramp_q <= wr_m[8:0];
                `A_SRT:     srt_q  <= wr_m[8:0];
                `A_JUMP:    jump_q <= wr_m[7:0];
                `A_IRQ_MSK: msk_q  <= wr_m[2:0];
                default: ;
            endcase
        end
    end

    // sticky events, write one to clear; a new event beats the clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sts_q <= 3'h0;
        end else if (wr_hit && awaddr == `A_IRQ_STS) begin
            sts_q <= (sts_q & ~wr_m[2:0]) | ev_q;
        end else begin
            sts_q <= sts_q | ev_q;
        end
    end

    // axi4-lite read
    always_comb begin
        case (araddr)
            `A_CTRL:    rd_d = {24'h0, ctrl_q};
            `A_FLC:     rd_d = {19'h0, flc_q};
            `A_SF:      rd_d = {24'h0, sf_q};
            `A_CLS:     rd_d = {26'h0, cls_q};
            `A_INIT:    rd_d = {22'h0, init_q};
            `A_MAX:     rd_d = {22'h0, max_q};
            `A_RAMP:    rd_d = {23'h0, ramp_q};
            `A_SRT:     rd_d = {23'h0, srt_q};
            `A_JUMP:    rd_d = {24'h0, jump_q};
            `A_STAT:    rd_d = {8'h0, fault_code_q, 1'b0, ol_state_q, 6'h0, state_q};
            `A_IRQ_STS: rd_d = {29'h0, sts_q};
            `A_IRQ_MSK: rd_d = {29'h0, msk_q};
            `A_LIMIT:   rd_d = {22'h0, lim_q};
            default:    rd_d = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ar_q    <= 1'b0;
            rv_q    <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= `RESP_OKAY;
        end else begin
            ar_q <= arvalid && !ar_q && !rv_q;
            if (ar_q && arvalid) begin
                rv_q    <= 1'b1;
                rdata_q <= rd_d;
                rresp_q <= (araddr > `A_LIMIT || araddr[1:0] != 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
            end else if (rready) begin
                rv_q <= 1'b0;
            end
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    AST_LOCAL_SRC: assert property (!ctrl_q[`F_LRIN] && !ctrl_q[`F_LR] |-> sel_src == ctrl_q[`F_LSRC]) // R3
        else $error("local source not chosen");
    AST_PIN_LOW: assert property (ctrl_q[`F_LRIN] && !lr_pin |-> sel_src == ctrl_q[`F_LSRC]) // R1
        else $error("pin low did not pick local");
    AST_PIN_HIGH: assert property (ctrl_q[`F_LRIN] && lr_pin |-> sel_src == ctrl_q[`F_RSRC]) // R2
        else $error("pin high did not pick remote");
    AST_KP_STOP: assert property (kp_stop && !ctrl_q[`F_KSD] |=> state_q == motor_ramp_pkg::ST_IDLE) // R5
        else $error("keypad stop ignored");
    AST_INIT: assert property ($rose(state_q == motor_ramp_pkg::ST_RAMP) |-> lim_q == $past(init_q)) // R11
        else $error("ramp did not start at initial current");
    AST_MONO: assert property (state_q == motor_ramp_pkg::ST_RAMP && $past(state_q) == motor_ramp_pkg::ST_RAMP // R19
        |-> lim_q >= $past(lim_q) && lim_q <= $past(lim_q) + 10'h001)
        else $error("ramp step not linear");
    AST_HOLD: assert property (state_q == motor_ramp_pkg::ST_HOLD |-> lim_q == max_q || $past(state_q) // R14
        == motor_ramp_pkg::ST_RAMP) else $error("hold not at maximum");
    AST_RUN: assert property (state_q == motor_ramp_pkg::ST_RUN ##1 state_q == motor_ramp_pkg::ST_RUN // R13
        |-> lim_q == $past(max_q)) else $error("run limit not maximum");
    AST_SPEED: assert property ($rose(state_q == motor_ramp_pkg::ST_RUN) |-> $past(cur_pct) < `SPEED_PCT) // R17
        else $error("up to speed above threshold");
    AST_STALL: assert property (ev_q[`EV_STALL] |-> fault_code_q == `FAULT_STALL ##1 sts_q[`EV_STALL]) // R18
        else $error("stall fault not raised");
    AST_OL_OFF: assert property (cls_q == 6'h00 |=> !ol_enable_q ##1 !ol_trip) // R10
        else $error("overload active while off");
    AST_JUMP: assert property (kp_enter |=> display_param_q == $past(jump_q)) // R16
        else $error("jump not taken");
    COV_RAMP_DONE: cover property (state_q == motor_ramp_pkg::ST_RAMP ##1 state_q == motor_ramp_pkg::ST_HOLD);
    COV_RUN: cover property (ev_q[`EV_SPEED]);
    COV_STALL: cover property (ev_q[`EV_STALL]);
endmodule : motor_ramp

// *** tb/starter_panel.sv ***
// Purpose: keypad, terminal strip, network master and motor feedback model
// Assumes: tasks are called by the bench right after a rising edge
// Notes:   commands are one-cycle pulses, idle low; feedback lines are levels
`timescale 1ns/10ps
module starter_panel (
    // clock
    input  wire logic clk,
    // command lines
    output logic       kp_start,
    output logic       kp_stop,
    output logic       kp_enter,
    output logic       ts_start,
    output logic       ts_stop,
    output logic       net_start,
    output logic       net_stop,
    output logic       lr_pin,
    // motor feedback
    output logic [9:0] cur_pct,
    output logic [6:0] ol_heat_pct
);
    initial begin
        {kp_start, kp_stop, kp_enter, ts_start, ts_stop, net_start, net_stop, lr_pin} = '0;
        cur_pct     = 10'h000;
        ol_heat_pct = 7'h00;
    end

    // source 0 keypad, 1 terminal, 2 network; one pulse so a single edge sees it
    task automatic press(input int src, input bit stp);
        @(posedge clk);
        case (src)
            0: if (stp) kp_stop <= 1'b1; else kp_start <= 1'b1;
            1: if (stp) ts_stop <= 1'b1; else ts_start <= 1'b1;
            default: if (stp) net_stop <= 1'b1; else net_start <= 1'b1;
        endcase
        @(posedge clk);
        {kp_start, kp_stop, ts_start, ts_stop, net_start, net_stop} <= '0;
    endtask : press

    task automatic enter();
        @(posedge clk);
        kp_enter <= 1'b1;
        @(posedge clk);
        kp_enter <= 1'b0;
    endtask : enter

    task automatic motor(input logic [9:0] c, input logic [6:0] h);
        @(posedge clk);
        cur_pct     <= c;
        ol_heat_pct <= h;
    endtask : motor

    task automatic sel(input logic v);
        @(posedge clk);
        lr_pin <= v;
    endtask : sel
endmodule : starter_panel

// *** tb/testbench.sv ***
// Purpose: self-checking bench of the start ramp block
// Assumes: short control tick so a ramp second is 4000 cycles
// Notes:   read results are queued by the driver and compared by a monitor
`timescale 1ns/10ps
`include "motor_ramp_cfg.svh"
module testbench;
    localparam int TK  = 4;
    localparam int SEC = 1000 * TK;
    logic        clk = 1'b0, arst_n = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic        kp_start, kp_stop, kp_enter, ts_start, ts_stop, net_start, net_stop, lr_pin;
    logic [9:0]  cur_pct;
    logic [6:0]  ol_heat_pct;
    logic        motor_run_q, up_to_speed_q, ol_enable_q, irq_q;
    logic [22:0] limit_ca_q;
    logic [7:0]  fault_code_q, service_factor_q, display_param_q;
    logic [5:0]  ol_class_q;
    int          n_mismatch = 0, total_checks = 0;
    logic [33:0] rq[$];
    logic [12:0] flc;
    logic [7:0]  jmp;

    always #2.5 clk = ~clk;

    motor_ramp #(.TICK_CYCLES(TK)) i_dut (.clk, .arst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .kp_start, .kp_stop, .kp_enter, .ts_start, .ts_stop, .net_start,
        .net_stop, .lr_pin, .cur_pct, .ol_heat_pct, .motor_run_q, .up_to_speed_q, .limit_ca_q,
        .fault_code_q, .service_factor_q, .ol_class_q, .ol_enable_q, .display_param_q, .irq_q);
    starter_panel i_op (.clk, .kp_start, .kp_stop, .kp_enter, .ts_start, .ts_stop, .net_start,
        .net_stop, .lr_pin, .cur_pct, .ol_heat_pct);

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    // address and data offered together, held until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do @(posedge clk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        check(bresp, er);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        rq.push_back({er, ed});
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask : rd

    // oldest note against each read answer
    always @(posedge clk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            check(rdata, rq[0][31:0]);
            check(rresp, rq[0][33:32]);
            void'(rq.pop_front());
        end
    end

    task automatic run_chk(input int src, input bit stp, input logic exp);
        i_op.press(src, stp);
        repeat (2) @(posedge clk);
        check(motor_run_q, exp);
    endtask : run_chk

    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        void'($urandom(32'h6803));
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        check(service_factor_q, 8'h73);
        check(ol_class_q, 6'h0a);
        check(ol_enable_q, 1'b1);
        rd(`A_CTRL, 32'h14, `RESP_OKAY);
        rd(`A_FLC, 32'h0a, `RESP_OKAY);
        rd(`A_SF, 32'h73, `RESP_OKAY);
        rd(`A_CLS, 32'h0a, `RESP_OKAY);
        rd(`A_INIT, 32'h64, `RESP_OKAY);
        rd(`A_MAX, 32'h258, `RESP_OKAY);
        rd(`A_RAMP, 32'h0f, `RESP_OKAY);
        rd(8'h40, 32'h0, `RESP_SLVERR);
        wr(8'h40, 32'h1, `RESP_SLVERR);
        wr(`A_STAT, 32'h3, `RESP_OKAY);
        $display("test reset_and_bus done");
        jmp = 8'($urandom);
        wr(`A_JUMP, {24'h0, jmp}, `RESP_OKAY);
        i_op.enter();
        repeat (2) @(posedge clk);
        check(display_param_q, jmp);
        $display("test jump done");
        // wrong source first, so a missing select shows as a start
        for (int s = 0; s < 3; s++) begin
            wr(`A_CTRL, 32'h10 | (s << 2), `RESP_OKAY);
            run_chk((s + 1) % 3, 0, 1'b0);
            run_chk(s, 0, 1'b1);
            run_chk(s, 1, 1'b0);
        end
        wr(`A_CTRL, 32'h60, `RESP_OKAY);
        i_op.sel(1'b1);
        run_chk(2, 0, 1'b1);
        run_chk(2, 1, 1'b0);
        i_op.sel(1'b0);
        run_chk(2, 0, 1'b0);
        wr(`A_CTRL, 32'h21, `RESP_OKAY);
        run_chk(2, 0, 1'b1);
        run_chk(2, 1, 1'b0);
        wr(`A_CTRL, 32'h14, `RESP_OKAY);
        run_chk(1, 0, 1'b1);
        run_chk(0, 1, 1'b0);
        wr(`A_CTRL, 32'h16, `RESP_OKAY);
        run_chk(1, 0, 1'b1);
        run_chk(0, 1, 1'b1);
        run_chk(1, 1, 1'b0);
        wr(`A_CTRL, 32'h1c, `RESP_OKAY);
        run_chk(1, 0, 1'b0);
        run_chk(0, 0, 1'b0);
        wr(`A_CTRL, 32'h14, `RESP_OKAY);
        $display("test sources done");
        flc = 13'($urandom_range(6400, 1));
        wr(`A_FLC, {19'h0, flc}, `RESP_OKAY);
        wr(`A_MAX, 32'hc8, `RESP_OKAY);
        wr(`A_RAMP, 32'h1, `RESP_OKAY);
        i_op.motor(10'd300, 7'h00);
        run_chk(1, 0, 1'b1);
        check(limit_ca_q, flc * 100);
        repeat (SEC / 2) @(posedge clk);
        check(limit_ca_q > flc * 100 && limit_ca_q < flc * 200, 1'b1);
        repeat (SEC / 2 + 20) @(posedge clk);
        check(limit_ca_q, flc * 200);
        rd(`A_STAT, 32'h2, `RESP_OKAY);
        repeat (SEC) @(posedge clk);
        check(limit_ca_q, flc * 200);
        i_op.motor(10'd175, 7'h00);
        repeat (10) @(posedge clk);
        check(up_to_speed_q, 1'b0);
        i_op.motor(10'd174, 7'h00);
        repeat (4) @(posedge clk);
        check(up_to_speed_q, 1'b1);
        check(limit_ca_q, flc * 200);
        rd(`A_IRQ_STS, 32'h2, `RESP_OKAY);
        run_chk(1, 1, 1'b0);
        $display("test ramp done");
        wr(`A_RAMP, 32'h0, `RESP_OKAY);
        wr(`A_SRT, 32'h1, `RESP_OKAY);
        wr(`A_IRQ_STS, 32'h7, `RESP_OKAY);
        wr(`A_IRQ_MSK, 32'h1, `RESP_OKAY);
        i_op.motor(10'd300, 7'h00);
        run_chk(1, 0, 1'b1);
        check(limit_ca_q, flc * 200);
        repeat (SEC + 20) @(posedge clk);
        check(motor_run_q, 1'b0);
        check(fault_code_q, 8'h01);
        check(irq_q, 1'b1);
        wr(`A_IRQ_MSK, 32'h0, `RESP_OKAY);
        repeat (2) @(posedge clk);
        check(irq_q, 1'b0);
        wr(`A_IRQ_MSK, 32'h1, `RESP_OKAY);
        wr(`A_IRQ_STS, 32'h1, `RESP_OKAY);
        repeat (2) @(posedge clk);
        check(irq_q, 1'b0);
        $display("test stall done");
        wr(`A_SRT, 32'h14, `RESP_OKAY);
        run_chk(1, 0, 1'b1);
        i_op.motor(10'd300, 7'h64);
        repeat (4) @(posedge clk);
        check(motor_run_q, 1'b0);
        rd(`A_IRQ_STS, 32'h4, `RESP_OKAY);
        wr(`A_CLS, 32'h0, `RESP_OKAY);
        repeat (2) @(posedge clk);
        check(ol_enable_q, 1'b0);
        run_chk(1, 0, 1'b1);
        repeat (10) @(posedge clk);
        check(motor_run_q, 1'b1);
        run_chk(1, 1, 1'b0);
        $display("test overload done");
        report_and_stop();
    end
endmodule : testbench
